// ### verilog/cell_monitor_pkg.sv
// constants and register layout for the cell monitor switch control block
package cell_monitor_pkg;
    localparam int          CLK_HZ          = 40_000_000;
    localparam logic [6:0]  SLAVE_ADDR      = 7'h5c;
    localparam logic [7:0]  IDX_CONTROL     = 8'h00;
    localparam logic [7:0]  IDX_BALANCE     = 8'h01;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  BALANCE_RESET   = 8'h00;
    localparam int          SLEEP_BIT       = 7;
    localparam int          WAKE_BIT        = 6;
    localparam int          MON_EN_BIT      = 5;
    localparam int          TAP_LSB         = 0;
    localparam int          TAP_W           = 3;
    localparam int          WAKE_FLAG_NS    = 10_000;
    localparam int          WAKE_EXIT_US    = 1_000;
    // least wake flag time rounds up to whole cycles
    localparam int WAKE_FLAG_CYC = (WAKE_FLAG_NS * (CLK_HZ / 1_000_000)
                                    + 999) / 1000;
    localparam int WAKE_EXIT_CYC = WAKE_EXIT_US * (CLK_HZ / 1_000_000);
endpackage

// ### verilog/pin_filter.sv
// wake pin qualifier: synchroniser plus high-time counter
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
    parameter int COUNT = 400
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic pin,
    output logic      qualified
);
    localparam int CW = $clog2(COUNT + 1);
    logic         sync1;
    logic         sync2;
    logic [CW-1:0] cnt;

    // elaboration check: a zero count would qualify any glitch
    if (COUNT < 1) begin : g_bad_count
        $error("pin_filter COUNT must be at least 1");
    end

    // two-stage synchroniser; sync1 is read only by sync2
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else if (ce) begin
            sync1 <= pin;
            sync2 <= sync1;
        end
    end

    // count high time; drop at once when the pin falls
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt       <= '0;
            qualified <= 1'b0;
        end else if (ce) begin
            if (!sync2) begin
                cnt       <= '0;
                qualified <= 1'b0;
            end else if (cnt >= CW'(COUNT)) begin
                qualified <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule // pin_filter
`default_nettype wire

// ### verilog/cell_monitor_ctrl.sv
// top of the cell monitor switch control block with its I2C slave
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_ctrl
    import cell_monitor_pkg::*;
#(
    parameter int WAKE_EXIT_COUNT = cell_monitor_pkg::WAKE_EXIT_CYC
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    input  wire logic       HIGH_VOLTAGE_WAKE_INPUT,
    input  wire logic       PRIMARY_DISCHARGE_CTL,
    input  wire logic       SECONDARY_DISCHARGE_CTL,
    input  wire logic       CHARGE_GATE_CTL,
    output logic [7:0]      TAP_SWITCHES_N,
    output logic [7:0]      BALANCE_SWITCHES,
    output logic            MONITOR_OUTPUT_EN,
    output logic            PRIMARY_DISCHARGE_GATE,
    output logic            SECONDARY_DISCHARGE_GATE,
    output logic            CHARGE_GATE_OUT,
    output logic            ASLEEP
);
    import cell_monitor_pkg::*;

    typedef enum {S_IDLE, S_ADDR, S_ACK, S_INDEX, S_DATA, S_READ,
                  S_RACK} i2c_state_t;

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic       scl_d;
    logic       sda_d;

    // pins from outside pass two flops before use; gate inputs reset
    // low so no gate pulses on while the pipeline refills after reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync1 <= 5'h18;
            sync2 <= 5'h18;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (CE) begin
            sync1 <= {SCL, SDA_IN, PRIMARY_DISCHARGE_CTL,
                      SECONDARY_DISCHARGE_CTL, CHARGE_GATE_CTL};
            sync2 <= sync1;
            scl_d <= sync2[4];
            sda_d <= sync2[3];
        end
    end

    wire scl_s   = sync2[4];
    wire sda_s   = sync2[3];
    wire start_c = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c  = scl_s && scl_d && !sda_d && sda_s;
    wire scl_up  = scl_s && !scl_d;
    wire scl_dn  = !scl_s && scl_d;

    // ***************************************************************
    // wake detection
    // ***************************************************************
    logic wake_flag;     // pin-derived wake event status
    logic wake_long;     // pin held past the sleep exit time
    logic host_wake;     // wake flag written by the host

    pin_filter #(.COUNT(WAKE_FLAG_CYC)) u_wake_flag (
        .clk       (SYS_CLK),
        .rst       (RST),
        .ce        (CE),
        .pin       (HIGH_VOLTAGE_WAKE_INPUT),
        .qualified (wake_flag)
    );
    pin_filter #(.COUNT(WAKE_EXIT_COUNT)) u_wake_exit (
        .clk       (SYS_CLK),
        .rst       (RST),
        .ce        (CE),
        .pin       (HIGH_VOLTAGE_WAKE_INPUT),
        .qualified (wake_long)
    );

    // ***************************************************************
    // I2C slave
    // ***************************************************************
    i2c_state_t  st;
    logic [7:0]  shreg;
    logic [3:0]  bitn;
    logic        rd;
    logic        ack_dn;
    logic        ack_slot;  // ninth clock of a byte: not a data bit
    logic [7:0]  index;
    logic        wr_stb;
    logic [7:0]  wr_data;
    logic [7:0]  control;
    logic [7:0]  balance;
    logic        sleep_bit;
    logic [7:0]  rd_word;
    wire  wake_any = wake_flag || host_wake;

    // read data: wake bit shows only the pin status
    always_comb begin
        rd_word = (index == IDX_BALANCE) ? balance : control;
        if (index == IDX_CONTROL) begin
            rd_word[WAKE_BIT]  = wake_flag;
            rd_word[SLEEP_BIT] = sleep_bit;
        end
    end

    // byte engine; samples and shifts in on scl rise, shifts out on scl fall
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st       <= S_IDLE;
            shreg    <= 8'h00;
            bitn     <= 4'h0;
            rd       <= 1'b0;
            index    <= 8'h00;
            wr_stb   <= 1'b0;
            wr_data  <= 8'h00;
            SDA_OUT  <= 1'b1;
            SDA_OE_N <= 1'b1;
            ack_dn   <= 1'b0;
            ack_slot <= 1'b0;
        end else if (CE) begin
            wr_stb <= 1'b0;
            if (start_c) begin
                st       <= S_ADDR;
                bitn     <= 4'h0;
                SDA_OE_N <= 1'b1;
                ack_slot <= 1'b0;
            end else if (stop_c) begin
                st       <= S_IDLE;
                SDA_OE_N <= 1'b1;
                ack_slot <= 1'b0;
            end else if (scl_up && st != S_IDLE) begin
                ack_dn <= sda_s;                     // master nack on read
                // the acknowledge clock must not count as a data bit
                if (!ack_slot) begin
                    bitn <= bitn + 4'h1;
                    if (st != S_READ)
                        shreg <= {shreg[6:0], sda_s};
                end
            end else if (scl_dn) begin
                SDA_OE_N <= 1'b1;
                ack_slot <= 1'b0;
                case (st)
                    S_ADDR:
                        if (bitn == 4'h8) begin
                            bitn <= 4'h0;
                            if (shreg[7:1] == SLAVE_ADDR) begin
                                rd       <= shreg[0];
                                st       <= S_ACK;
                                SDA_OUT  <= 1'b0;
                                SDA_OE_N <= 1'b0;
                                ack_slot <= 1'b1;
                            end else begin
                                st <= S_IDLE;
                            end
                        end
                    S_ACK: begin
                        bitn <= 4'h0;
                        if (rd) begin
                            st       <= S_READ;
                            shreg    <= {rd_word[6:0], 1'b0};
                            SDA_OUT  <= rd_word[7];
                            SDA_OE_N <= !rd_word[7] ? 1'b0 : 1'b1;
                        end else begin
                            st <= S_INDEX;
                        end
                    end
                    S_INDEX:
                        if (bitn == 4'h8) begin
                            index    <= shreg;
                            st       <= S_DATA;
                            bitn     <= 4'h0;
                            SDA_OUT  <= 1'b0;
                            SDA_OE_N <= 1'b0;
                            ack_slot <= 1'b1;
                        end
                    S_DATA:
                        if (bitn == 4'h8) begin
                            wr_stb   <= 1'b1;
                            wr_data  <= shreg;
                            bitn     <= 4'h0;
                            SDA_OUT  <= 1'b0;
                            SDA_OE_N <= 1'b0;
                            ack_slot <= 1'b1;
                        end else if (bitn == 4'h0) begin
                            SDA_OE_N <= 1'b1;
                        end
                    S_READ:
                        if (bitn == 4'h8) begin
                            st       <= S_RACK;
                            bitn     <= 4'h0;
                            ack_slot <= 1'b1;
                        end else begin
                            SDA_OUT  <= shreg[7];
                            SDA_OE_N <= !shreg[7] ? 1'b0 : 1'b1;
                            shreg    <= {shreg[6:0], 1'b0};
                        end
                    // master ack: next byte starts on this very fall
                    S_RACK:
                        if (ack_dn) begin
                            st <= S_IDLE;
                        end else begin
                            st       <= S_READ;
                            shreg    <= {rd_word[6:0], 1'b0};
                            SDA_OUT  <= rd_word[7];
                            SDA_OE_N <= !rd_word[7] ? 1'b0 : 1'b1;
                        end
                    default: st <= S_IDLE;
                endcase
            end
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    // control fields and balance enables; sleep clears balancing
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            control   <= CONTROL_RESET;
            balance   <= BALANCE_RESET;
            sleep_bit <= 1'b0;
            host_wake <= 1'b0;
        end else if (CE) begin
            if (wr_stb && index == IDX_CONTROL) begin
                control   <= wr_data;
                host_wake <= wr_data[WAKE_BIT];
            end
            if (wr_stb && index == IDX_BALANCE)
                balance <= wr_data;
            if (wake_any || (sleep_bit && wake_long)) begin
                sleep_bit <= 1'b0;
            end else if (wr_stb && index == IDX_CONTROL) begin
                sleep_bit <= wr_data[SLEEP_BIT];
                if (wr_data[SLEEP_BIT])
                    balance <= 8'h00;
            end
        end
    end

    // ***************************************************************
    // outputs, all registered; all but ASLEEP gated by sleep
    // ***************************************************************
    logic [7:0] next_taps;
    always_comb begin
        next_taps = 8'hff;
        if (control[MON_EN_BIT] && !sleep_bit)
            next_taps[control[TAP_LSB +: TAP_W]] = 1'b0;
    end

    // gate drivers and switches; floating inputs resolve low off-chip
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            TAP_SWITCHES_N           <= 8'hff;
            BALANCE_SWITCHES         <= 8'h00;
            MONITOR_OUTPUT_EN        <= 1'b0;
            PRIMARY_DISCHARGE_GATE   <= 1'b0;
            SECONDARY_DISCHARGE_GATE <= 1'b0;
            CHARGE_GATE_OUT          <= 1'b0;
            ASLEEP                   <= 1'b0;
        end else if (CE) begin
            TAP_SWITCHES_N           <= next_taps;
            BALANCE_SWITCHES         <= sleep_bit ? 8'h00 : balance;
            MONITOR_OUTPUT_EN        <= control[MON_EN_BIT] && !sleep_bit;
            PRIMARY_DISCHARGE_GATE   <= !sleep_bit && sync2[2];
            SECONDARY_DISCHARGE_GATE <= !sleep_bit && sync2[1];
            CHARGE_GATE_OUT          <= !sleep_bit && sync2[0];
            ASLEEP                   <= sleep_bit;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_tap_onehot: assert property (CE && $past(CE) && !ASLEEP
        && MONITOR_OUTPUT_EN |-> $countones(~TAP_SWITCHES_N) == 1)
        else $error("tap switches not one-hot");
    a_sleep_balance: assert property (CE && sleep_bit |=> !CE ||
        BALANCE_SWITCHES == 8'h00)
        else $error("balance on in sleep");
    a_prim_gate: assert property (CE && (sleep_bit || !sync2[2])
        |=> !CE || !PRIMARY_DISCHARGE_GATE)
        else $error("primary gate on wrongly");
    a_sec_gate: assert property (CE && (sleep_bit || !sync2[1])
        |=> !CE || !SECONDARY_DISCHARGE_GATE)
        else $error("secondary gate on wrongly");
    a_chg_gate: assert property (CE && !sleep_bit && sync2[0]
        |=> !CE || CHARGE_GATE_OUT)
        else $error("charge gate not on");
    a_wake_holds: assert property (CE && wake_any |=> !sleep_bit)
        else $error("sleep bit set during wake event");
    a_sleep_entry: assert property (CE && wr_stb && index == IDX_CONTROL
        && wr_data[SLEEP_BIT] && !wake_any && !wake_long
        |=> sleep_bit)
        else $error("sleep command lost");
    a_sleep_outs: assert property (CE && sleep_bit |=> !CE ||
        (TAP_SWITCHES_N == 8'hff && !MONITOR_OUTPUT_EN))
        else $error("outputs live in sleep");
    c_sleep: cover property (sleep_bit ##[1:1000] !sleep_bit);
    c_write: cover property (wr_stb && index == IDX_BALANCE);
    c_wake: cover property (wake_flag);
endmodule // cell_monitor_ctrl
`default_nettype wire

// ### test/i2c_host_model.sv
// behavioural I2C host that drives the control block's serial port
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    import cell_monitor_pkg::*;
    // half period twice the slave's minimum phase, so sync lag is harmless
    localparam int PH = 8;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        step(PH);
        scl <= 1'b1;
        step(PH);
        r = sda;
        scl <= 1'b0;
        step(PH);
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start_c;
        sda_drv <= 1'b1;
        step(PH);
        scl <= 1'b1;
        step(PH);
        sda_drv <= 1'b0;
        step(PH);
        scl <= 1'b0;
        step(PH);
    endtask
    task automatic stop_c;
        sda_drv <= 1'b0;
        step(PH);
        scl <= 1'b1;
        step(PH);
        sda_drv <= 1'b1;
        step(PH);
    endtask
    // eight bits msb first, then the ninth bit; last=1 releases the line
    task automatic byte_io(input logic [7:0] tx, input logic last,
                           output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(last, r);
        ack = !r;
    endtask
    task automatic probe(input logic [6:0] a, output logic ok);
        logic [7:0] rx;
        start_c();
        byte_io({a, 1'b0}, 1'b1, rx, ok);
        stop_c();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start_c();
        byte_io({SLAVE_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(idx, 1'b1, rx, a1);
        byte_io(d, 1'b1, rx, a2);
        stop_c();
        ok = a0 & a1 & a2;
    endtask
    // index write, repeated start, one byte read and refused with nack
    task automatic rd(input logic [7:0] idx, output logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, nk;
        start_c();
        byte_io({SLAVE_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(idx, 1'b1, rx, a1);
        start_c();
        byte_io({SLAVE_ADDR, 1'b1}, 1'b1, rx, a2);
        byte_io(8'hff, 1'b1, d, nk);
        stop_c();
        ok = a0 & a1 & a2;
    endtask
endmodule // i2c_host_model
`default_nettype wire

// ### test/cell_monitor_switch_control_bench.sv
// self-checking bench for the cell monitor switch control block
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_switch_control_bench;
    import cell_monitor_pkg::*;
    localparam int EXIT_CYC = 50; // short sleep-exit count keeps runs brief
    logic sys_clk, rst, hv, d0, d1, cg, scl, sda_drv, sda, sda_out, oe_n;
    logic [7:0] taps_n, bal;
    logic mon, g0, g1, gc, asleep, ok, ce;
    logic [7:0] v;
    int err_total, check_count;
    // open-drain data wire with a pull-up; both parties only pull low
    assign sda = sda_drv & (oe_n | sda_out);
    cell_monitor_ctrl #(.WAKE_EXIT_COUNT(EXIT_CYC)) DUT (
        .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(oe_n),
        .HIGH_VOLTAGE_WAKE_INPUT(hv), .PRIMARY_DISCHARGE_CTL(d0),
        .SECONDARY_DISCHARGE_CTL(d1), .CHARGE_GATE_CTL(cg),
        .TAP_SWITCHES_N(taps_n), .BALANCE_SWITCHES(bal),
        .MONITOR_OUTPUT_EN(mon), .PRIMARY_DISCHARGE_GATE(g0),
        .SECONDARY_DISCHARGE_GATE(g1), .CHARGE_GATE_OUT(gc),
        .ASLEEP(asleep));
    i2c_host_model host (.clk(sys_clk), .scl(scl), .sda_drv(sda_drv),
                         .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ************************************************
    // checking helpers
    // ************************************************
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.wr(idx, d, ok);
        chk(8'(ok), 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        host.rd(idx, v, ok);
        chk(8'(ok), 8'h01);
        chk(v, exp);
    endtask
    // bounded wait for the sleep state, a hang ends the run
    task automatic wait_asleep(input logic want, input int bound);
        for (int n = 0; n < bound && asleep !== want; n++) begin
            @(posedge sys_clk);
        end
        chk(8'(asleep), 8'(want));
        if (asleep !== want) test_done();
    endtask
    task automatic chk_off;
        chk(taps_n, 8'hff);
        chk(bal, 8'h00);
        chk({4'h0, mon, g0, g1, gc}, 8'h00);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        test_done();
    end
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {rst, hv, d0, d1, cg} = 5'b10000;
        ce = 1'b1;
        err_total = 0;
        check_count = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_off();
        rd_chk(IDX_CONTROL, CONTROL_RESET);
        rd_chk(IDX_BALANCE, BALANCE_RESET);
        host.probe(SLAVE_ADDR ^ 7'h01, ok);
        chk(8'(ok), 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(IDX_CONTROL, 8'h38 | 8'(k));
            chk(taps_n, ~(8'h01 << k));
            chk(8'(mon), 8'h01);
        end
        rd_chk(IDX_CONTROL, 8'h3f);
        wr(IDX_CONTROL, 8'h07);
        chk(taps_n, 8'hff);
        // non-adjacent patterns only, the host keeps channel currents equal
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h55 : (i == 1) ? 8'haa : 8'h81;
            wr(IDX_BALANCE, v);
            chk(bal, v);
            rd_chk(IDX_BALANCE, v);
        end
        for (int i = 0; i < 8; i++) begin
            {d0, d1, cg} <= 3'(i);
            repeat (5) @(posedge sys_clk);
            chk({5'h0, g0, g1, gc}, 8'(i));
        end
        // clock enable low freezes the gate outputs
        ce <= 1'b0;
        {d0, d1, cg} <= 3'b000;
        repeat (5) @(posedge sys_clk);
        chk({5'h0, g0, g1, gc}, 8'h07);
        ce <= 1'b1;
        {d0, d1, cg} <= 3'b111;
        repeat (5) @(posedge sys_clk);
        chk({5'h0, g0, g1, gc}, 8'h07);
        wr(IDX_CONTROL, 8'h80);
        wait_asleep(1'b1, 8);
        chk_off();
        rd_chk(IDX_CONTROL, 8'h80);
        rd_chk(IDX_BALANCE, 8'h00);
        hv <= 1'b1;
        wait_asleep(1'b0, EXIT_CYC + 20);
        repeat (5) @(posedge sys_clk);
        chk({5'h0, g0, g1, gc}, 8'h07);
        repeat (420) @(posedge sys_clk);
        rd_chk(IDX_CONTROL, 8'h40);
        wr(IDX_CONTROL, 8'h80);
        chk(8'(asleep), 8'h00);
        rd_chk(IDX_CONTROL, 8'h40);
        hv <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd_chk(IDX_CONTROL, 8'h00);
        // host-written wake flag also blocks sleep until cleared
        wr(IDX_CONTROL, 8'h40);
        wr(IDX_CONTROL, 8'h80);
        chk(8'(asleep), 8'h00);
        rd_chk(IDX_CONTROL, 8'h00);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CONTROL, 8'h80);
        wait_asleep(1'b1, 8);
        wr(IDX_CONTROL, 8'h00);
        wait_asleep(1'b0, 8);
        test_done();
    end
endmodule // cell_monitor_switch_control_bench
`default_nettype wire
